// ===== hw/ppoc_pkg.sv
// Package: register map, field layout and carrier types of the pin stage
package ppoc_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] PPOC_IO_CONTROL_OFS = 8'h00;
    localparam logic [7:0] PPOC_STATUS_OFS = 8'h04;

    // Field positions inside the I/O control register
    localparam int PPOC_HIGH_OWNER_BIT = 15;
    localparam int PPOC_LOW_OWNER_BIT = 14;
    localparam int PPOC_HIGH_POL_BIT = 13;
    localparam int PPOC_LOW_POL_BIT = 12;
    localparam int PPOC_MODE_LSB = 10;
    localparam int PPOC_SWAP_BIT = 1;
    localparam int PPOC_OVERRIDE_SYNC_BIT = 0;

    // Reset value: both pins owned by the generator, all else clear
    localparam logic [15:0] PPOC_IO_CONTROL_RST = 16'hC000;

    // Pin pair modes
    localparam logic [1:0] PPOC_MODE_COMPL = 2'h0;
    localparam logic [1:0] PPOC_MODE_REDUN = 2'h1;
    localparam logic [1:0] PPOC_MODE_PUSHPULL = 2'h2;
    localparam logic [1:0] PPOC_MODE_INDEP = 2'h3;

    // Fault response mode code that disables the fault override
    localparam logic [1:0] PPOC_FLT_MODE_OFF = 2'h3;

    // Layout of the I/O control register, bit 15 first
    typedef struct packed {
        logic high_pin_owner;
        logic low_pin_owner;
        logic high_pin_polarity;
        logic low_pin_polarity;
        logic [1:0] pin_pair_mode;
        logic high_override_enable;
        logic low_override_enable;
        logic [1:0] override_pin_data;
        logic [1:0] fault_pin_data;
        logic [1:0] current_limit_pin_data;
        logic swap;
        logic override_sync;
    } ppoc_io_control_type;

    // A high and low signal that travel together
    typedef struct packed {
        logic high;
        logic low;
    } ppoc_pin_pair_type;

    // Override settings as currently applied to the pins
    typedef struct packed {
        logic en_high;
        logic en_low;
        logic dat_high;
        logic dat_low;
    } ppoc_override_type;

endpackage : ppoc_pkg

// ===== hw/ppoc_top.sv
// PWM pin output stage: pair modes, override, fault, swap and polarity
`timescale 1ns/1ps
module ppoc_top (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Time base and duty logic, same clock
    input wire logic pwm_module_enable_i,
    input wire logic period_start_i,
    input wire ppoc_pkg::ppoc_pin_pair_type gen_pair_i,
    // Fault and current-limit control
    input wire logic fault_i,
    input wire logic current_limit_i,
    input wire logic current_limit_mode_enable_i,
    input wire logic independent_fault_select_i,
    input wire logic [1:0] fault_response_mode_i,
    // Output pins to the gate drivers
    output logic high_side_output_o,
    output logic low_side_output_o,
    output logic high_side_oe_o,
    output logic low_side_oe_o
);
    import ppoc_pkg::*;

    // Bus state
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    ppoc_io_control_type cfg_reg; // Software configuration
    ppoc_io_control_type cfg_next;

    // Asynchronous fault inputs, three stages each
    logic [1:0] ext_in;
    logic [2:0] sync_reg [2];
    logic [1:0] ext_act_reg; // Filtered level: [1] fault, [0] limit
    logic [1:0] ext_act_next;

    // Pin stage state
    logic pp_phase_reg; // Push-pull: which pin owns this period
    logic pp_phase_next;
    ppoc_override_type ovr_act_reg; // Override settings in force
    ppoc_override_type ovr_act_next;
    ppoc_pin_pair_type logic_pair; // Logical levels before routing
    ppoc_pin_pair_type pin_pair; // Levels after swap
    ppoc_pin_pair_type out_reg;
    ppoc_pin_pair_type out_next;
    ppoc_pin_pair_type oe_reg;
    ppoc_pin_pair_type oe_next;
    logic flt_on; // Fault override active
    logic cl_on; // Current-limit override active
    logic bus_req;
    logic [15:0] wmask;

    // Bus request without an answer pending
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;

    // Bus: ack, read data and register writes
    always_comb
    begin
        ack_next = bus_req;
        rdata_next = rdata_reg;
        cfg_next = cfg_reg;
        wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        // Read data is presented together with ack
        if (bus_req)
        begin
            unique case (wb_adr_i)
                PPOC_IO_CONTROL_OFS:
                    rdata_next = {16'h0000, cfg_reg};
                PPOC_STATUS_OFS:
                    rdata_next = {24'h000000, out_reg, oe_reg,
                                  ext_act_reg, pp_phase_reg,
                                  ovr_act_reg.en_high};
                default:
                    rdata_next = 32'h00000000; // Unmapped reads zero
            endcase
        end
        // Write takes effect on the edge that ack is seen
        if (wb_cyc_i && wb_stb_i && wb_we_i && ack_reg &&
            wb_adr_i == PPOC_IO_CONTROL_OFS)
        begin
            cfg_next = (cfg_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
        end
    end

    // Bus registers
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            cfg_reg <= PPOC_IO_CONTROL_RST;
        end
        else
        begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            cfg_reg <= cfg_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // Fault and limit pins pass three flops each
    assign ext_in = {fault_i, current_limit_i};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_sync
            // Shift chain; only stage 1 reads stage 0
            always_ff @(posedge ref_clk_i or posedge rst_i)
            begin
                if (rst_i)
                    sync_reg[gi] <= 3'h0;
                else
                    sync_reg[gi] <= {sync_reg[gi][1:0], ext_in[gi]};
            end
            // A change counts once stages 1 and 2 agree
            always_comb
            begin
                ext_act_next[gi] = ext_act_reg[gi];
                if (sync_reg[gi][1] == sync_reg[gi][2])
                    ext_act_next[gi] = sync_reg[gi][2];
            end
        end
    endgenerate

    // Filtered fault levels
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            ext_act_reg <= 2'h0;
        else
            ext_act_reg <= ext_act_next;
    end

    assign flt_on = ext_act_reg[1] &&
                    (fault_response_mode_i != PPOC_FLT_MODE_OFF);
    assign cl_on = ext_act_reg[0] && current_limit_mode_enable_i;

    // Pin stage: mode, override, limit, fault, swap, polarity
    always_comb
    begin
        // Push-pull alternates pins every period
        pp_phase_next = pp_phase_reg;
        if (!pwm_module_enable_i)
            pp_phase_next = 1'b0;
        else if (period_start_i)
            pp_phase_next = !pp_phase_reg;
        // Override settings: at once or at period start
        ovr_act_next = ovr_act_reg;
        if (!cfg_reg.override_sync || period_start_i)
        begin
            ovr_act_next = {cfg_reg.high_override_enable,
                            cfg_reg.low_override_enable,
                            cfg_reg.override_pin_data};
        end
        // Pair mode shapes the generator signals
        unique case (cfg_reg.pin_pair_mode)
            PPOC_MODE_COMPL:
                logic_pair = {gen_pair_i.high, !gen_pair_i.high};
            PPOC_MODE_REDUN:
                logic_pair = {gen_pair_i.high, gen_pair_i.high};
            PPOC_MODE_PUSHPULL:
                logic_pair = {gen_pair_i.high && !pp_phase_reg,
                              gen_pair_i.high && pp_phase_reg};
            PPOC_MODE_INDEP:
                logic_pair = gen_pair_i;
        endcase
        // Disabled generator leaves both pins inactive
        if (!pwm_module_enable_i)
            logic_pair = 2'h0;
        // Software override per pin
        if (ovr_act_reg.en_high)
            logic_pair.high = ovr_act_reg.dat_high;
        if (ovr_act_reg.en_low)
            logic_pair.low = ovr_act_reg.dat_low;
        if (!independent_fault_select_i)
        begin
            // Normal mode: limit then fault, both pins
            if (cl_on)
                logic_pair = cfg_reg.current_limit_pin_data;
            if (flt_on)
                logic_pair = cfg_reg.fault_pin_data;
        end
        else
        begin
            // Independent mode: fault to high, limit to low
            if (flt_on)
                logic_pair.high = cfg_reg.fault_pin_data[1];
            if (cl_on)
                logic_pair.low = cfg_reg.fault_pin_data[0];
        end
        // Swap exchanges the routing of the two signals
        if (cfg_reg.swap)
            pin_pair = {logic_pair.low, logic_pair.high};
        else
            pin_pair = logic_pair;
        // Logical levels become electrical through polarity
        out_next.high = pin_pair.high ^ cfg_reg.high_pin_polarity;
        out_next.low = pin_pair.low ^ cfg_reg.low_pin_polarity;
        // Owner bit decides who drives each pin
        oe_next = {cfg_reg.high_pin_owner, cfg_reg.low_pin_owner};
    end

    // Pin stage registers
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pp_phase_reg <= 1'b0;
            ovr_act_reg <= 4'h0;
            out_reg <= 2'h0;
            oe_reg <= 2'h0;
        end
        else
        begin
            pp_phase_reg <= pp_phase_next;
            ovr_act_reg <= ovr_act_next;
            out_reg <= out_next;
            oe_reg <= oe_next;
        end
    end

    assign high_side_output_o = out_reg.high;
    assign low_side_output_o = out_reg.low;
    assign high_side_oe_o = oe_reg.high;
    assign low_side_oe_o = oe_reg.low;

    // Quiet pair: no fault, limit or swap in the way
    logic quiet;
    assign quiet = !flt_on && !cl_on && !cfg_reg.swap;

    property p_high_pol;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ovr_act_reg.en_high && quiet) |=> high_side_output_o ==
            ($past(ovr_act_reg.dat_high) ^ $past(cfg_reg.high_pin_polarity));
    endproperty
    a_high_pol: assert property (p_high_pol)
        else $error("high pin level does not follow polarity");

    property p_low_pol;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ovr_act_reg.en_low && quiet) |=> low_side_output_o ==
            ($past(ovr_act_reg.dat_low) ^ $past(cfg_reg.low_pin_polarity));
    endproperty
    a_low_pol: assert property (p_low_pol)
        else $error("low pin level does not follow polarity");

    property p_pol_indep;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ovr_act_reg == 4'hC && quiet &&
         cfg_reg.high_pin_polarity != cfg_reg.low_pin_polarity)
        |=> high_side_output_o != low_side_output_o;
    endproperty
    a_pol_indep: assert property (p_pol_indep)
        else $error("pin polarities are not independent");

    property p_redundant;
        @(posedge ref_clk_i) disable iff (rst_i)
        (cfg_reg.pin_pair_mode == PPOC_MODE_REDUN && quiet &&
         ovr_act_reg[3:2] == 2'h0 &&
         cfg_reg.high_pin_polarity == cfg_reg.low_pin_polarity)
        |=> high_side_output_o == low_side_output_o;
    endproperty
    a_redundant: assert property (p_redundant)
        else $error("redundant pair pins differ");

    property p_fault_level;
        @(posedge ref_clk_i) disable iff (rst_i)
        (flt_on && !independent_fault_select_i && !cfg_reg.swap)
        |=> low_side_output_o == ($past(cfg_reg.fault_pin_data[0]) ^
                                  $past(cfg_reg.low_pin_polarity));
    endproperty
    a_fault_level: assert property (p_fault_level)
        else $error("fault data not applied as logical level");

    property p_owner;
        @(posedge ref_clk_i) disable iff (rst_i)
        $changed(cfg_reg.high_pin_owner) |=>
            high_side_oe_o == $past(cfg_reg.high_pin_owner);
    endproperty
    a_owner: assert property (p_owner)
        else $error("high pin enable does not follow owner bit");

    property p_climit;
        @(posedge ref_clk_i) disable iff (rst_i)
        (cl_on && !flt_on && !independent_fault_select_i &&
         !cfg_reg.swap) |=> high_side_output_o ==
            ($past(cfg_reg.current_limit_pin_data[1]) ^
             $past(cfg_reg.high_pin_polarity));
    endproperty
    a_climit: assert property (p_climit)
        else $error("current limit data not applied to high pin");

    property p_swap;
        @(posedge ref_clk_i) disable iff (rst_i)
        (cfg_reg.swap && !flt_on && !cl_on && ovr_act_reg.en_low)
        |=> high_side_output_o == ($past(ovr_act_reg.dat_low) ^
                                   $past(cfg_reg.high_pin_polarity));
    endproperty
    a_swap: assert property (p_swap)
        else $error("swap did not route low signal to high pin");

    property p_override_sync_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        (cfg_reg.override_sync && !period_start_i) |=> $stable(ovr_act_reg);
    endproperty
    a_override_sync_hold: assert property (p_override_sync_hold)
        else $error("override changed between period starts");

    property p_ack_pulse;
        @(posedge ref_clk_i) disable iff (rst_i)
        bus_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("bus ack is not a single cycle pulse");

endmodule : ppoc_top

// ===== tb/ppoc_gate_driver_model.sv
// Gate driver model: resolves both pins as seen at the driver inputs
`timescale 1ns/1ps
module ppoc_gate_driver_model (
    // Pin drive from the output stage
    input wire logic high_side_output_i,
    input wire logic low_side_output_i,
    input wire logic high_side_oe_i,
    input wire logic low_side_oe_i,
    // Levels seen by the drivers
    output logic high_level_o,
    output logic low_level_o
);
    // A released pin falls to the pull-down, never the last value
    assign high_level_o = high_side_oe_i ? high_side_output_i : 1'b0;
    assign low_level_o = low_side_oe_i ? low_side_output_i : 1'b0;
endmodule : ppoc_gate_driver_model

// ===== tb/ppoc_top_tb_top.sv
// Testbench: bus tasks and pin checks for the PWM pin output stage
`timescale 1ns/1ps
module ppoc_top_tb_top;
    import ppoc_pkg::*;
    // Clock, reset and bus master drive
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic [31:0] q;
    // Time base, generator and fault inputs
    logic en = 1'b1;
    logic ps = 1'b0;
    ppoc_pin_pair_type gen = '0;
    logic flt = 1'b0;
    logic lim = 1'b0;
    logic lim_en = 1'b0;
    logic indep = 1'b0;
    logic [1:0] fmode = 2'h3;
    // Pin outputs and resolved levels
    logic hs;
    logic ls;
    logic hoe;
    logic loe;
    logic hpin;
    logic lpin;
    int error_cnt = 0;
    int num_checks = 0;
    // Pair mode, polarity and swap settings swept against the generator
    logic [15:0] tbl [7] = '{16'hC000, 16'hC400, 16'hCC00, 16'hEC00,
        16'hDC00, 16'hCC02, 16'hF402};

    // Clock of 20 ns
    always #10 ref_clk_i = ~ref_clk_i;

    ppoc_top u_dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pwm_module_enable_i(en), .period_start_i(ps), .gen_pair_i(gen),
        .fault_i(flt), .current_limit_i(lim),
        .current_limit_mode_enable_i(lim_en),
        .independent_fault_select_i(indep),
        .fault_response_mode_i(fmode), .high_side_output_o(hs),
        .low_side_output_o(ls), .high_side_oe_o(hoe), .low_side_oe_o(loe)
    );

    ppoc_gate_driver_model u_drv (
        .high_side_output_i(hs), .low_side_output_i(ls),
        .high_side_oe_i(hoe), .low_side_oe_i(loe),
        .high_level_o(hpin), .low_level_o(lpin)
    );

    // Logical pair per mode, then swap, then polarity per pin
    function automatic logic [1:0] exp_pins(input logic [15:0] c,
        input logic [1:0] g);
        logic h;
        logic l;
        h = g[1];
        l = (c[11:10] == PPOC_MODE_COMPL) ? ~g[1] :
            (c[11:10] == PPOC_MODE_REDUN) ? g[1] : g[0];
        if (c[1])
            {h, l} = {l, h};
        return {h ^ c[13], l ^ c[12]};
    endfunction : exp_pins

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] s);
        num_checks++;
        if (s !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
            error_cnt++;
        end
    endtask : chk

    // One classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        int i;
        i = 0;
        @(posedge ref_clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        // Wait for ack; only the watchdog ends a hung wait
        do
        begin
            @(posedge ref_clk_i);
            i++;
        end
        while (ack !== 1'b1);
        r = rdat;
        // Ack is sampled high on the second edge after the request
        chk("wb_ack_wait", 32'h2, i);
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge ref_clk_i);
    endtask : wb

    // Register write
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] r;
        wb(1'b1, a, {16'h0, d}, r);
    endtask : wr

    // Pair mode change with the generator stopped around it
    task automatic mode_wr(input logic [15:0] d);
        en <= 1'b0;
        wr(PPOC_IO_CONTROL_OFS, d);
        en <= 1'b1;
    endtask : mode_wr

    // Wait n edges, then compare the resolved pins
    task automatic pins(input string nm, input logic [1:0] e, input int n);
        repeat (n) @(posedge ref_clk_i);
        chk(nm, {30'h0, e}, {30'h0, hpin, lpin});
    endtask : pins

    // One period start pulse
    task automatic pulse;
        @(posedge ref_clk_i);
        ps <= 1'b1;
        @(posedge ref_clk_i);
        ps <= 1'b0;
    endtask : pulse

    // Verdict and end of run
    task automatic give_verdict;
        if (error_cnt == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    // Watchdog against a hung handshake
    initial
    begin
        #1000000;
        error_cnt++;
        give_verdict();
    end

    // Main sequence
    initial
    begin
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        wb(1'b0, PPOC_IO_CONTROL_OFS, 32'h0, q);
        chk("ctrl_reset", 32'h0000C000, q);
        wr(8'h08, 16'h1234);
        wb(1'b0, 8'h08, 32'h0, q);
        chk("unmapped_read", 32'h0, q);
        wb(1'b0, PPOC_IO_CONTROL_OFS, 32'h0, q);
        chk("ctrl_kept", 32'h0000C000, q);
        // Sweep modes, polarities and swap
        for (int c = 0; c < 7; c++)
        begin
            mode_wr(tbl[c]);
            for (int g = 0; g < 4; g++)
            begin
                gen <= g[1:0];
                pins("pair_table", exp_pins(tbl[c], g[1:0]), 3);
            end
        end
        // Override, then synchronised override
        gen <= 2'b01;
        mode_wr(16'hC380);
        pins("override", 2'b10, 3);
        wr(PPOC_IO_CONTROL_OFS, 16'hC381);
        wr(PPOC_IO_CONTROL_OFS, 16'hC341);
        pins("override_sync_hold", 2'b10, 3);
        pulse();
        pins("override_sync_apply", 2'b01, 3);
        // Fault above override, then current limit
        wr(PPOC_IO_CONTROL_OFS, 16'hC390);
        fmode <= 2'h0;
        flt <= 1'b1;
        pins("fault_data", 2'b01, 7);
        flt <= 1'b0;
        lim_en <= 1'b1;
        lim <= 1'b1;
        wr(PPOC_IO_CONTROL_OFS, 16'hC39C);
        pins("limit_data", 2'b11, 7);
        wr(PPOC_IO_CONTROL_OFS, 16'hE39C);
        pins("limit_polarity", 2'b01, 3);
        // Independent mode ignores the limit data
        indep <= 1'b1;
        gen <= 2'b00;
        mode_wr(16'hCC0C);
        pins("indep_limit", 2'b00, 3);
        indep <= 1'b0;
        lim <= 1'b0;
        lim_en <= 1'b0;
        fmode <= 2'h3;
        // Push-pull alternates the pins, with the module stopped first
        en <= 1'b0;
        gen <= 2'b10;
        wr(PPOC_IO_CONTROL_OFS, 16'hC800);
        pins("stopped", 2'b00, 3);
        en <= 1'b1;
        pins("pp_phase0", 2'b10, 3);
        pulse();
        pins("pp_phase1", 2'b01, 3);
        // Status: pins 01, both enables, no fault or limit, phase 1
        wb(1'b0, PPOC_STATUS_OFS, 32'h0, q);
        chk("status", 32'h00000072, q);
        // Released pins, active-low setting must not reach the drivers
        gen <= 2'b00;
        en <= 1'b0;
        wr(PPOC_IO_CONTROL_OFS, 16'h3000);
        pins("released", 2'b00, 3);
        chk("oe_off", 32'h0, {30'h0, hoe, loe});
        wb(1'b0, PPOC_IO_CONTROL_OFS, 32'h0, q);
        chk("ctrl_read", 32'h00003000, q);
        give_verdict();
    end
endmodule : ppoc_top_tb_top
